// ===== dv/tb_top.sv
// Self-checking bench for the flash self-program controller.
`timescale 1ns/10ps
`include "fspc_consts.svh"
module tb_top;
    import fspc_pkg::*;
    logic          ref_clk;
    logic          rst_n;
    fspc_avs_req_t req;
    logic [31:0]   rdata;
    logic          wreq;
    logic          prog_on;
    logic          dbg_on;
    logic          tb_da;
    logic          tb_ck;
    fspc_pin_drv_t da_drv;
    fspc_pin_drv_t ck_drv;
    fspc_pin_drv_t g_da;
    fspc_pin_drv_t g_ck;
    int            failures;
    int            n_checks;
    // The shared data wire follows the device while it drives, the bench otherwise.
    wire logic     da_lvl = da_drv.oe ? da_drv.o : tb_da;

    fspc_flash_ctrl #(.PAGE_MODE(1'b1), .ADDR_W(12)) fspc_flash_ctrl_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .prog_mode_active(prog_on),
        .on_chip_debug_active(dbg_on), .prog_serial_data_pin_level(da_lvl),
        .prog_serial_clock_pin_level(tb_ck), .prog_serial_data_pin_drive(da_drv),
        .prog_serial_clock_pin_drive(ck_drv), .gpio_data_drive(g_da),
        .gpio_clock_drive(g_ck));

    // Free-running 40 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        req.write   <= wr;
        req.read    <= ~wr;
        req.address <= a;
        req.writedata <= d;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        if (n >= 50)
            chk(32'h0000_0001, 32'h0000_0000);
        req.write <= 1'b0;
        req.read  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic expect_reg(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    // Polls a register until the masked busy bits fall; a bounded wait.
    task automatic poll(input logic [3:0] a, input logic [31:0] m);
        logic [31:0] q;
        int          n;
        n = 0;
        do
        begin
            bus(1'b0, a, 32'h0000_0000, q);
            n++;
        end while ((q & m) !== 32'h0000_0000 && n < 200);
        chk(q & m, 32'h0000_0000);
    endtask

    task automatic t_reset();
        chk({31'h0, wreq}, 32'h0000_0001);
        expect_reg(`FSPC_OFF_CTRL, 32'h0000_0000);
        expect_reg(`FSPC_OFF_DATA_LO, 32'h0000_0000);
        expect_reg(4'hF, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_locked();
        wr(`FSPC_OFF_CTRL, 32'h0000_0024);
        expect_reg(`FSPC_OFF_CTRL, 32'h0000_0020);
        wr(`FSPC_OFF_DATA_LO, 32'h0000_005A);
        expect_reg(`FSPC_OFF_DATA_LO, 32'h0000_0000);
        wr(`FSPC_OFF_KEY, 32'h0000_00A5);
        wr(`FSPC_OFF_KEY, 32'h0000_005A);
        expect_reg(`FSPC_OFF_CTRL, 32'h0000_00A0);
        $display("test locked done");
    endtask

    // Erases the page holding the given low address; low offset bits are ignored.
    task automatic t_erase(input logic [7:0] lo);
        logic [31:0] q;
        wr(`FSPC_OFF_ADDR_HI, 32'h0000_0000);
        wr(`FSPC_OFF_ADDR_LO, {24'h0, lo});
        wr(`FSPC_OFF_CTRL, 32'h0000_0094);
        bus(1'b0, `FSPC_OFF_CTRL, 32'h0000_0000, q);
        chk(q & 32'h0000_0004, 32'h0000_0004);
        poll(`FSPC_OFF_CTRL, 32'h0000_0004);
        $display("test erase done");
    endtask

    task automatic t_fill();
        wr(`FSPC_OFF_ADDR_LO, 32'h0000_0000);
        wr(`FSPC_OFF_DATA_LO, 32'h0000_0034);
        wr(`FSPC_OFF_DATA_HI, 32'h0000_0012);
        expect_reg(`FSPC_OFF_ADDR_LO, 32'h0000_0001);
        wr(`FSPC_OFF_ADDR_LO, 32'h0000_001F);
        wr(`FSPC_OFF_DATA_LO, 32'h0000_00CD);
        wr(`FSPC_OFF_DATA_HI, 32'h0000_00AB);
        expect_reg(`FSPC_OFF_ADDR_LO, 32'h0000_001F);
        wr(`FSPC_OFF_CTRL, 32'h0000_00A4);
        poll(`FSPC_OFF_CTRL, 32'h0000_0004);
        $display("test fill done");
    endtask

    task automatic t_read(input logic [7:0] lo, input logic [15:0] exp);
        wr(`FSPC_OFF_ADDR_LO, {24'h0, lo});
        wr(`FSPC_OFF_CTRL, 32'h0000_0082);
        wr(`FSPC_OFF_CTRL, 32'h0000_0083);
        poll(`FSPC_OFF_CTRL, 32'h0000_0001);
        expect_reg(`FSPC_OFF_DATA_LO, {24'h0, exp[7:0]});
        expect_reg(`FSPC_OFF_DATA_HI, {24'h0, exp[15:8]});
        $display("test read done");
    endtask

    task automatic t_read_refused();
        wr(`FSPC_OFF_CTRL, 32'h0000_0080);
        wr(`FSPC_OFF_CTRL, 32'h0000_0081);
        expect_reg(`FSPC_OFF_CTRL, 32'h0000_0080);
        $display("test read refused done");
    endtask

    // A word staged before a buffer clear must not reach the flash.
    task automatic t_clear();
        t_erase(8'h40);
        wr(`FSPC_OFF_ADDR_LO, 32'h0000_0044);
        wr(`FSPC_OFF_DATA_LO, 32'h0000_0011);
        wr(`FSPC_OFF_DATA_HI, 32'h0000_0022);
        wr(`FSPC_OFF_CLR_BUF, 32'h0000_0001);
        poll(`FSPC_OFF_CLR_BUF, 32'h0000_0001);
        wr(`FSPC_OFF_CTRL, 32'h0000_00A4);
        poll(`FSPC_OFF_CTRL, 32'h0000_0004);
        t_read(8'h44, 16'hFFFF);
        $display("test clear done");
    endtask

    // Shifts a word address in on rising clocks, then takes 16 data bits out.
    task automatic t_serial(input logic [15:0] a, input logic [15:0] exp);
        for (int i = 15; i >= 0; i--)
        begin
            tb_ck <= 1'b0;
            tb_da <= a[i];
            cyc(4);
            tb_ck <= 1'b1;
            cyc(4);
        end
        tb_da <= ~exp[15];
        cyc(4);
        chk({30'h0, da_drv}, {30'h0, exp[15], 1'b1});
        for (int i = 14; i >= 0; i--)
        begin
            tb_ck <= 1'b0;
            cyc(8);
            chk({30'h0, da_drv}, {30'h0, exp[i], 1'b1});
            tb_ck <= 1'b1;
            cyc(4);
        end
        tb_ck <= 1'b0;
        cyc(8);
        chk({31'h0, da_drv.oe}, 32'h0000_0000);
    endtask

    task automatic t_pins();
        g_da <= '{o: 1'b1, oe: 1'b1};
        g_ck <= '{o: 1'b1, oe: 1'b1};
        cyc(3);
        chk({28'h0, da_drv, ck_drv}, 32'h0000_000F);
        prog_on <= 1'b1;
        cyc(3);
        chk({28'h0, da_drv, ck_drv}, 32'h0000_0000);
        t_serial(16'h001F, 16'hABCD);
        prog_on <= 1'b0;
        cyc(3);
        dbg_on <= 1'b1;
        cyc(3);
        t_serial(16'h0000, 16'h1234);
        dbg_on <= 1'b0;
        $display("test pins done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        failures = 0;
        n_checks = 0;
        rst_n = 1'b0;
        req = '0;
        req.byteenable = 4'h1;
        prog_on = 1'b0;
        dbg_on = 1'b0;
        tb_da = 1'b0;
        tb_ck = 1'b0;
        g_da = '0;
        g_ck = '0;
        cyc(5);
        rst_n <= 1'b1;
        t_reset();
        t_locked();
        t_erase(8'h07);
        t_fill();
        t_read(8'h00, 16'h1234);
        t_read(8'h01, 16'hFFFF);
        t_read(8'h1F, 16'hABCD);
        t_read_refused();
        t_clear();
        t_pins();
        tally_and_finish();
    end

    // Watchdog: the tests need well under 20000 cycles.
    initial
    begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end
endmodule

// ===== logic/fspc_consts.svh
// Register offsets, field positions, unlock keys, erased word and timing counts.
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
// Word offsets on the Avalon slave; byte address is four times the offset.
`define FSPC_OFF_CTRL       4'h0
`define FSPC_OFF_ADDR_LO    4'h1
`define FSPC_OFF_ADDR_HI    4'h2
`define FSPC_OFF_DATA_LO    4'h3
`define FSPC_OFF_DATA_HI    4'h4
`define FSPC_OFF_CLR_BUF    4'h5
`define FSPC_OFF_KEY        4'h6
// Control register fields.
`define FSPC_CTRL_EN_BIT    7
`define FSPC_CTRL_MODE_HI   6
`define FSPC_CTRL_MODE_LO   4
`define FSPC_CTRL_WR_BIT    2
`define FSPC_CTRL_RDEN_BIT  1
`define FSPC_CTRL_RD_BIT    0
`define FSPC_MODE_ERASE     3'h1
`define FSPC_MODE_WRITE     3'h2
// Unlock keys for the erase/write enable procedure.
`define FSPC_KEY_FIRST      8'hA5
`define FSPC_KEY_SECOND     8'h5A
`define FSPC_ERASED_WORD    16'hFFFF
// Operation times and the cycle counts derived from the clock rate.
`define FSPC_CLK_MHZ        40
`define FSPC_ERASE_TIME_US  4
`define FSPC_WRITE_TIME_US  2
`define FSPC_READ_TIME_NS   100
`define FSPC_CLEAR_TIME_NS  100
`define FSPC_ERASE_CYC      (`FSPC_ERASE_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_WRITE_CYC      (`FSPC_WRITE_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_READ_CYC       (`FSPC_READ_TIME_NS * `FSPC_CLK_MHZ / 1000)
`define FSPC_CLEAR_CYC      (`FSPC_CLEAR_TIME_NS * `FSPC_CLK_MHZ / 1000)
`endif

// ===== logic/fspc_flash_ctrl.sv
// Flash self-program sequencer with Avalon-MM registers and serial pin pair.
//
// Function
// - Block variant erases 256-word blocks, writes four words, reads one word.
// - Page variant erases and writes 32-word pages via 32-word buffer.
// - Erase/write enabled flag rises only after the unlock procedure completes.
// - Data registers and buffer accept writes only while enabled flag is high.
// - Software sets write start; it stays high while busy, hardware clears it.
// - A read may start only while the read enable bit is set.
// - Read start flag stays high during the read, cleared when done.
// - Block variant: high bits select block, low bits [7:2] the write unit.
// - Page variant: page is high register plus low bits [7:5].
// - Serial data pin carries address in and data out, clocked by programmer.
// - Debug data pin is bidirectional, debug clock pin only an input.
// - Other functions on the two pins are inert while the link is active.
// - The debug pins also serve as the in-circuit programming pins.
// - Writing the data high byte loads the buffer and increments the address.
// - Address stops incrementing at the last word of a page, or of a four-word write unit in the block variant.
// - Buffer clear bit self-clears; buffer also clears after every write.
`timescale 1ns/10ps
`include "fspc_consts.svh"
module fspc_flash_ctrl
    import fspc_pkg::*;
#(
    parameter bit PAGE_MODE = 1'b1,
    parameter int ADDR_W    = 12
)(
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Avalon-MM slave.
    input  wire fspc_avs_req_t avs_req,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    // Link mode selects.
    input  wire logic          prog_mode_active,
    input  wire logic          on_chip_debug_active,
    // Shared pin pair.
    input  wire logic          prog_serial_data_pin_level,
    input  wire logic          prog_serial_clock_pin_level,
    output fspc_pin_drv_t      prog_serial_data_pin_drive,
    output fspc_pin_drv_t      prog_serial_clock_pin_drive,
    // Normal pin functions that share the pair.
    input  wire fspc_pin_drv_t gpio_data_drive,
    input  wire fspc_pin_drv_t gpio_clock_drive
);
    localparam int FLASH_WORDS = 1 << ADDR_W;
    localparam int UNIT        = PAGE_MODE ? 32 : 4;
    localparam int ERASE_WORDS = PAGE_MODE ? 32 : 256;
    localparam int OFS_W       = PAGE_MODE ? 5 : 2;

    logic [15:0]       flash_mem [FLASH_WORDS];
    logic [15:0]       buf_reg [UNIT];
    logic [ADDR_W-1:0] fa_reg;
    logic [7:0]        data_lo_reg, data_hi_reg;
    logic              en_reg, key_stage_reg, wflag_reg, rden_reg, rflag_reg, clr_reg;
    logic [2:0]        mode_reg;
    fspc_state_t       state_reg;
    logic [7:0]        timer_reg;
    logic [31:0]       rd_next;
    logic [7:0]        wd;
    logic              wr_be, idle, fin, wr_ctrl, start_wr, start_rd, start_clr;
    logic              data_hi_load, at_end;
    logic [ADDR_W-1:0] wbase, ebase;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // A request is taken at the edge where waitrequest is seen low.
    assign wr_be = avs_req.write & ~avs_waitrequest & avs_req.byteenable[0];
    assign wd    = avs_req.writedata[7:0];
    assign idle  = (state_reg == ST_IDLE);
    assign fin   = ~idle & (timer_reg == 8'h00);

    // Starts are screened here so a refused start never touches its flag.
    assign wr_ctrl   = wr_be & (avs_req.address == `FSPC_OFF_CTRL);
    assign start_wr  = wr_ctrl & wd[`FSPC_CTRL_WR_BIT] & en_reg & idle
                     & ((wd[6:4] == `FSPC_MODE_ERASE) | (wd[6:4] == `FSPC_MODE_WRITE));
    assign start_rd  = wr_ctrl & wd[`FSPC_CTRL_RD_BIT] & rden_reg & idle
                     & ~start_wr;
    assign start_clr = wr_be & (avs_req.address == `FSPC_OFF_CLR_BUF) & wd[0] & idle;

    // Target bases: the low offset bits are ignored for erase and write.
    assign wbase = fa_reg & ~ADDR_W'(UNIT - 1);
    assign ebase = fa_reg & ~ADDR_W'(ERASE_WORDS - 1);
    assign data_hi_load = wr_be & (avs_req.address == `FSPC_OFF_DATA_HI) & en_reg;
    assign at_end = &fa_reg[OFS_W-1:0];

    // Waitrequest drops for one cycle per request, so every access takes two cycles.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~(avs_waitrequest & (avs_req.read | avs_req.write));
    end

    // Read data is loaded as waitrequest falls, so it stands at the taking edge.
    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (avs_req.address)
            `FSPC_OFF_CTRL:    rd_next[7:0] = {en_reg, mode_reg, 1'b0,
                                               wflag_reg, rden_reg, rflag_reg};
            `FSPC_OFF_ADDR_LO: rd_next[7:0] = fa_reg[7:0];
            `FSPC_OFF_ADDR_HI: rd_next[7:0] = 8'(fa_reg[ADDR_W-1:8]);
            `FSPC_OFF_DATA_LO: rd_next[7:0] = data_lo_reg;
            `FSPC_OFF_DATA_HI: rd_next[7:0] = data_hi_reg;
            `FSPC_OFF_CLR_BUF: rd_next[0]   = clr_reg;
            default:           rd_next      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_waitrequest & avs_req.read)
            avs_readdata <= rd_next;
    end

    // Unlock: two keys in a row raise the enable flag; software may drop it when idle.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {en_reg, key_stage_reg} <= 2'h0;
        else if (wr_be & (avs_req.address == `FSPC_OFF_KEY))
        begin
            key_stage_reg <= (wd == `FSPC_KEY_FIRST);
            if (key_stage_reg & (wd == `FSPC_KEY_SECOND))
                en_reg <= 1'b1;
        end
        else if (wr_ctrl & ~wd[`FSPC_CTRL_EN_BIT] & idle)
            en_reg <= 1'b0;
    end

    // Mode and read enable are plain software bits.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {mode_reg, rden_reg} <= 4'h0;
        else if (wr_ctrl)
        begin
            mode_reg <= wd[`FSPC_CTRL_MODE_HI:`FSPC_CTRL_MODE_LO];
            rden_reg <= wd[`FSPC_CTRL_RDEN_BIT];
        end
    end

    // Busy flags. Starts only happen when idle, so a set never meets a clear.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {wflag_reg, rflag_reg, clr_reg} <= 3'h0;
        else
        begin
            if (start_wr)
                wflag_reg <= 1'b1;
            else if (fin & ((state_reg == ST_ERASE) | (state_reg == ST_WRITE)))
                wflag_reg <= 1'b0;
            if (start_rd)
                rflag_reg <= 1'b1;
            else if (fin & (state_reg == ST_READ))
                rflag_reg <= 1'b0;
            if (start_clr)
                clr_reg <= 1'b1;
            else if (fin & (state_reg == ST_CLEAR))
                clr_reg <= 1'b0;
        end
    end

    // Sequencer: one operation at a time, each timed by its own count.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            timer_reg <= 8'h00;
        end
        else if (idle)
        begin
            if (start_wr & (wd[6:4] == `FSPC_MODE_ERASE))
            begin
                state_reg <= ST_ERASE;
                timer_reg <= 8'(`FSPC_ERASE_CYC - 1);
            end
            else if (start_wr)
            begin
                state_reg <= ST_WRITE;
                timer_reg <= 8'(`FSPC_WRITE_CYC - 1);
            end
            else if (start_rd)
            begin
                state_reg <= ST_READ;
                timer_reg <= 8'(`FSPC_READ_CYC - 1);
            end
            else if (start_clr)
            begin
                state_reg <= ST_CLEAR;
                timer_reg <= 8'(`FSPC_CLEAR_CYC - 1);
            end
        end
        else if (fin)
            state_reg <= ST_IDLE;
        else
            timer_reg <= timer_reg - 8'h01;
    end

    // Flash array; erase fills with the erased word, write copies the whole buffer.
    // It has no reset, being storage and not control state.
    always_ff @(posedge ref_clk)
    begin
        if (fin & (state_reg == ST_ERASE))
        begin
            for (int i = 0; i < ERASE_WORDS; i++)
                flash_mem[ebase | ADDR_W'(i)] <= `FSPC_ERASED_WORD;
        end
        else if (fin & (state_reg == ST_WRITE))
        begin
            for (int i = 0; i < UNIT; i++)
                flash_mem[wbase | ADDR_W'(i)] <= buf_reg[i];
        end
    end

    // Write buffer: loaded by the data high byte, cleared on request and after writes.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < UNIT; i++)
                buf_reg[i] <= `FSPC_ERASED_WORD;
        end
        else if (fin & ((state_reg == ST_WRITE) | (state_reg == ST_CLEAR)))
        begin
            for (int i = 0; i < UNIT; i++)
                buf_reg[i] <= `FSPC_ERASED_WORD;
        end
        else if (data_hi_load)
            buf_reg[fa_reg[OFS_W-1:0]] <= {wd, data_lo_reg};
    end

    // Data registers take software bytes when enabled and the word of a finished read.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {data_lo_reg, data_hi_reg} <= 16'h0000;
        else if (fin & (state_reg == ST_READ))
            {data_hi_reg, data_lo_reg} <= flash_mem[fa_reg];
        else if (wr_be & en_reg)
        begin
            if (avs_req.address == `FSPC_OFF_DATA_LO)
                data_lo_reg <= wd;
            if (avs_req.address == `FSPC_OFF_DATA_HI)
                data_hi_reg <= wd;
        end
    end

    // Address pair; a data high load steps it but never past the unit's last word.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            fa_reg <= '0;
        else if (data_hi_load)
        begin
            if (!at_end)
                fa_reg <= fa_reg + ADDR_W'(1);
        end
        else if (wr_be & (avs_req.address == `FSPC_OFF_ADDR_LO))
            fa_reg[7:0] <= wd;
        else if (wr_be & (avs_req.address == `FSPC_OFF_ADDR_HI))
            fa_reg[ADDR_W-1:8] <= wd[ADDR_W-9:0];
    end

    // Serial link: 16 address bits in on rising clock edges, then 16 data bits out.
    // The clock pin is sampled directly; it is taken as synchronous to ref_clk.
    logic              link_on, sclk_prev_reg, sdata_phase_reg, srise, sfall;
    logic [4:0]        sbit_reg;
    logic [15:0]       sshift_reg;
    assign link_on = prog_mode_active | on_chip_debug_active;
    assign srise   = prog_serial_clock_pin_level & ~sclk_prev_reg;
    assign sfall   = ~prog_serial_clock_pin_level & sclk_prev_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {sclk_prev_reg, sbit_reg, sdata_phase_reg, sshift_reg} <= '0;
        else if (!link_on)
        begin
            sclk_prev_reg   <= prog_serial_clock_pin_level;
            sbit_reg        <= 5'h00;
            sdata_phase_reg <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= prog_serial_clock_pin_level;
            if (srise & !sdata_phase_reg)
            begin
                sshift_reg <= {sshift_reg[14:0], prog_serial_data_pin_level};
                sbit_reg   <= sbit_reg + 5'h01;
                if (sbit_reg == 5'h0F)
                    sdata_phase_reg <= 1'b1;
            end
            else if (sdata_phase_reg & (sbit_reg == 5'h10))
            begin
                sshift_reg <= flash_mem[sshift_reg[ADDR_W-1:0]];
                sbit_reg   <= 5'h11;
            end
            else if (sfall & sdata_phase_reg)
            begin
                // The count wraps to zero on the fifteenth fall; the sixteenth ends the word.
                if (sbit_reg == 5'h00)
                    sdata_phase_reg <= 1'b0;
                else
                begin
                    sshift_reg <= {sshift_reg[14:0], 1'b0};
                    sbit_reg   <= sbit_reg + 5'h01;
                end
            end
        end
    end

    // Pin ownership: the link takes both pins and the shared functions go inert.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            {prog_serial_data_pin_drive, prog_serial_clock_pin_drive} <= '0;
        else if (link_on)
        begin
            prog_serial_data_pin_drive.o  <= sshift_reg[15];
            prog_serial_data_pin_drive.oe <= sdata_phase_reg & (sbit_reg != 5'h10);
            prog_serial_clock_pin_drive   <= '0;
        end
        else
        begin
            prog_serial_data_pin_drive  <= gpio_data_drive;
            prog_serial_clock_pin_drive <= gpio_clock_drive;
        end
    end

    AST_WFLAG_NEEDS_EN: assert property ($rose(wflag_reg) |-> $past(en_reg))
        else $error("write start rose while not enabled");
    AST_DATA_GATED: assert property ($changed(data_lo_reg) && $past(idle) |-> $past(en_reg))
        else $error("data register changed while not enabled");
    AST_WFLAG_BUSY: assert property ((state_reg == ST_WRITE) |-> wflag_reg ##1 wflag_reg || idle)
        else $error("write flag low during write");
    AST_WFLAG_END: assert property ($rose(wflag_reg) |-> ##[1:200] !wflag_reg)
        else $error("write flag not cleared in time");
    AST_READ_EN: assert property ($rose(rflag_reg) |-> $past(rden_reg))
        else $error("read started without read enable");
    AST_READ_DONE: assert property ($rose(rflag_reg) |-> rflag_reg[*4] ##1 !rflag_reg)
        else $error("read flag length wrong");
    AST_ADDR_INC: assert property (data_hi_load && !at_end |=> fa_reg == $past(fa_reg) + ADDR_W'(1))
        else $error("address did not step after high byte");
    AST_ADDR_HOLD: assert property (data_hi_load && at_end |=> $stable(fa_reg))
        else $error("address moved past last word");
    AST_BUF_CLEARED: assert property ($fell(wflag_reg) && $past(state_reg) == ST_WRITE
        |-> buf_reg[0] == `FSPC_ERASED_WORD)
        else $error("buffer not cleared after write");
    AST_ONE_OP: assert property (!(wflag_reg && rflag_reg))
        else $error("read and write busy together");
    AST_PIN_INERT: assert property (link_on |=> !prog_serial_clock_pin_drive.oe)
        else $error("clock pin driven while link active");
endmodule

// ===== logic/fspc_pkg.sv
// Types shared by the flash self-program controller.
package fspc_pkg;
    // Avalon-MM request bundle from the bus master.
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } fspc_avs_req_t;
    // Drive side of a shared pin: level and output enable.
    typedef struct packed {
        logic o;
        logic oe;
    } fspc_pin_drv_t;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ERASE,
        ST_WRITE,
        ST_READ,
        ST_CLEAR
    } fspc_state_t;
endpackage
